// file: design/spd_top.sv
`timescale 1ns/1ns
`include "spd_defines.svh"
module spd_top (
  input wire logic CLOCK_I, // 20 MHz core clock
  input wire logic RESET_I, // async reset, high
  input wire logic [3:0] ADDR_I, // register address
  input wire logic [7:0] WDATA_I, // register write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [7:0] RDATA_O, // read data, cycle after strobe
  input wire logic SCSI_RST_N_I, // bus reset pin, low active
  input wire logic SCSI_REQ_I, // bus REQ, high = asserted
  input wire logic SCSI_ACK_I, // bus ACK
  input wire logic SCSI_IO_I, // bus I/O, 1 = in direction
  input wire logic SCSI_CD_I, // bus C/D
  input wire logic SCSI_MSG_I, // bus MSG
  input wire logic SCSI_BSY_I, // bus BSY
  input wire logic SCSI_SEL_I, // bus SEL
  input wire logic [15:0] SCSI_DATA_I, // bus data
  output logic SCSI_REQ_O, // REQ drive
  output logic SCSI_ACK_O, // ACK drive
  output logic [15:0] SCSI_DATA_O, // data drive value
  output logic SCSI_DATA_OE_O, // data drive enable
  output logic TERM_POWER_OUT_O, // termination power level
  output logic TERM_POWER_OE_O, // termination power enable
  output logic SYNC_XFER_O, // synchronous data timing
  output logic WIDE_XFER_O, // wide data timing
  output logic SEQ_PAUSED_O, // sequencer held paused
  output logic [3:0] DIFF_PORT_DATA_O, // differential port data
  output logic DIFF_PORT_STROBE_O, // differential port strobe
  output logic [1:0] DIFF_PORT_ADDR_O // differential port address
);
  import spd_pkg::*;

  logic [7:0] ctl_s; // synced {rst_n, sel, bsy, msg, cd, io, req, ack}
  logic [15:0] bus_s; // synced data lines
  logic rst_n_s, sel_s, bsy_s, msg_s, cd_s, io_s, req_s, ack_s;
  logic term_pol_reg, term_en_reg; // termination bits
  logic auto_reg, target_reg; // auto pio enable, role
  logic pause_reg; // sequencer pause
  logic [3:0] own_id_reg; // own id field
  logic [7:0] dll_reg, dlh_reg; // data latches
  logic [7:0] sigo_reg; // manual signal outputs
  logic [7:0] rate_reg; // transfer rate
  logic ready_reg; // pio ready flag
  logic bus_free_reg; // bus-free status
  logic [7:0] free_cnt_reg; // bus-free qualification count
  logic won_reg, lost_reg; // arbitration result
  logic id_pend_reg; // own id port write owed
  logic [7:0] arb_cnt_reg; // arbitration timer
  spd_hs_t hs_reg; // handshake state
  spd_arb_t arb_reg; // arbitration state
  logic wr_dll, rd_dll, chip_rst, id_wr, arb_start, cmd_phase;
  logic arb_wr, dw_busy, dw_req, arb_go;
  logic [1:0] arb_adr, dw_adr;
  logic [3:0] arb_dat, dw_dat;
  logic [7:0] rd_mux;

  // every bus pin passes the three-stage filter; bus reset idles high
  spd_sync #(.W(8), .INIT(8'h80)) u_sync_ctl (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .d_i({SCSI_RST_N_I, SCSI_SEL_I, SCSI_BSY_I, SCSI_MSG_I,
          SCSI_CD_I, SCSI_IO_I, SCSI_REQ_I, SCSI_ACK_I}),
    .q_o(ctl_s)
  );
  spd_sync #(.W(16), .INIT(16'h0000)) u_sync_dat (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .d_i(SCSI_DATA_I),
    .q_o(bus_s)
  );
  assign {rst_n_s, sel_s, bsy_s, msg_s, cd_s, io_s, req_s, ack_s} = ctl_s;

  // register strobes and side-effect pulses
  assign wr_dll = WR_I && (ADDR_I == `SPD_OFF_DLL);
  assign rd_dll = RD_I && (ADDR_I == `SPD_OFF_DLL);
  assign chip_rst = WR_I && (ADDR_I == `SPD_OFF_HCTL) && WDATA_I[`SPD_B_SOFT_CHIP_RESET];
  assign id_wr = WR_I && (ADDR_I == `SPD_OFF_OWNID);
  assign arb_start = WR_I && (ADDR_I == `SPD_OFF_ARB) && WDATA_I[`SPD_B_START];
  assign cmd_phase = cd_s && !msg_s && !io_s;

  // termination power control; bus reset beats everything else
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      term_pol_reg <= 1'b0;
      term_en_reg <= 1'b0;
      TERM_POWER_OE_O <= 1'b0;
    end else if (!rst_n_s) begin
      term_pol_reg <= 1'b0;
      term_en_reg <= 1'b0;
      TERM_POWER_OE_O <= 1'b0;
    end else begin
      if (WR_I && (ADDR_I == `SPD_OFF_DEVCFG))
        term_pol_reg <= WDATA_I[`SPD_B_TPOL];
      if (chip_rst)
        term_en_reg <= 1'b0;
      else if (WR_I && (ADDR_I == `SPD_OFF_XC1))
        term_en_reg <= WDATA_I[`SPD_B_TEN];
      // once driven, the pin stays driven until the next bus reset
      if (WR_I && (ADDR_I == `SPD_OFF_XC1) && WDATA_I[`SPD_B_TEN] && !chip_rst)
        TERM_POWER_OE_O <= 1'b1;
    end
  end

  // active level: polarity zero means high is active
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I)
      TERM_POWER_OUT_O <= 1'b0;
    else
      TERM_POWER_OUT_O <= term_en_reg ^ term_pol_reg;
  end

  // plain control registers; chip reset turns automatic functions off
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pause_reg <= 1'b1;
      auto_reg <= 1'b0;
      target_reg <= 1'b0;
      own_id_reg <= 4'h0;
      sigo_reg <= 8'h00;
      rate_reg <= 8'h00;
    end else if (chip_rst) begin
      pause_reg <= 1'b1;
      auto_reg <= 1'b0;
      sigo_reg <= 8'h00;
    end else if (WR_I) begin
      case (ADDR_I)
        `SPD_OFF_HCTL: pause_reg <= WDATA_I[`SPD_B_PAUSE];
        `SPD_OFF_XC0: begin
          auto_reg <= WDATA_I[`SPD_B_AUTO];
          target_reg <= WDATA_I[`SPD_B_TARGET];
        end
        `SPD_OFF_OWNID: own_id_reg <= WDATA_I[3:0];
        `SPD_OFF_SIGO: sigo_reg <= WDATA_I;
        `SPD_OFF_RATE: rate_reg <= WDATA_I;
        default: ;
      endcase
    end
  end

  // automatic pio handshake; HS_IDLE both sets ready (initiator) and clears it (target)
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hs_reg <= HS_IDLE;
      ready_reg <= 1'b0;
    end else if (chip_rst || !auto_reg) begin
      hs_reg <= HS_IDLE; // manual mode: no handshake logic
      ready_reg <= 1'b0;
    end else begin
      case (hs_reg)
        HS_IDLE: begin
          if (!target_reg && req_s) begin
            ready_reg <= 1'b1;
            hs_reg <= HS_READY;
          end else if (target_reg && rd_dll && !io_s) begin
            ready_reg <= 1'b0;
            hs_reg <= HS_STROBE;
          end else if (target_reg && wr_dll && io_s) begin
            ready_reg <= 1'b0;
            hs_reg <= HS_SETUP;
          end
        end
        HS_READY: begin
          if (wr_dll && !io_s) begin
            ready_reg <= 1'b0;
            hs_reg <= HS_SETUP;
          end else if (rd_dll && io_s) begin
            ready_reg <= 1'b0;
            hs_reg <= HS_STROBE;
          end
        end
        HS_SETUP: hs_reg <= HS_STROBE; // data settles before the strobe
        HS_STROBE: begin
          if (!target_reg && !req_s)
            hs_reg <= HS_IDLE;
          else if (target_reg && ack_s) begin
            ready_reg <= 1'b1;
            hs_reg <= HS_RELEASE;
          end
        end
        HS_RELEASE: if (!ack_s) hs_reg <= HS_IDLE;
        default: hs_reg <= HS_IDLE;
      endcase
    end
  end

  // data latches: host writes, or bus capture during auto handshakes
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dll_reg <= 8'h00;
      dlh_reg <= 8'h00;
    end else begin
      if (WR_I && (ADDR_I == `SPD_OFF_DLH))
        dlh_reg <= WDATA_I;
      if (wr_dll)
        dll_reg <= WDATA_I;
      else if (auto_reg && !chip_rst &&
               ((hs_reg == HS_IDLE && !target_reg && req_s && io_s) ||
                (hs_reg == HS_STROBE && target_reg && ack_s && !io_s))) begin
        dll_reg <= bus_s[7:0];
        dlh_reg <= bus_s[15:8];
      end
    end
  end

  // bus drivers; in auto mode the party that owns the data drives it
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SCSI_REQ_O <= 1'b0;
      SCSI_ACK_O <= 1'b0;
      SCSI_DATA_OE_O <= 1'b0;
      SCSI_DATA_O <= 16'h0000;
    end else begin
      SCSI_DATA_O <= {dlh_reg, dll_reg};
      if (auto_reg) begin
        SCSI_REQ_O <= target_reg && (hs_reg == HS_STROBE);
        SCSI_ACK_O <= !target_reg && (hs_reg == HS_STROBE);
        SCSI_DATA_OE_O <= (hs_reg == HS_SETUP || hs_reg == HS_STROBE) &&
                          (target_reg == io_s);
      end else begin
        SCSI_REQ_O <= sigo_reg[`SPD_B_SIGO_REQ];
        SCSI_ACK_O <= sigo_reg[`SPD_B_SIGO_ACK];
        SCSI_DATA_OE_O <= sigo_reg[`SPD_B_SIGO_DRV];
      end
    end
  end

  // rate shapes every phase but command; command phase stays asynchronous
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SYNC_XFER_O <= 1'b0;
      WIDE_XFER_O <= 1'b0;
      SEQ_PAUSED_O <= 1'b1;
    end else begin
      SYNC_XFER_O <= (rate_reg[3:0] != 4'h0) && !cmd_phase;
      WIDE_XFER_O <= rate_reg[`SPD_B_WIDE] && !cmd_phase;
      SEQ_PAUSED_O <= pause_reg;
    end
  end

  // bus free once BSY and SEL stay low for the qualification time
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      free_cnt_reg <= 8'h00;
      bus_free_reg <= 1'b0;
    end else if (bsy_s || sel_s) begin
      free_cnt_reg <= 8'h00;
      bus_free_reg <= 1'b0;
    end else if (free_cnt_reg == 8'(`SPD_BUS_FREE_CYC - 1)) begin
      bus_free_reg <= 1'b1;
    end else begin
      free_cnt_reg <= free_cnt_reg + 8'h01;
    end
  end

  // priority 7 high down to 0, then 15 down to 8; any higher id loses us
  function automatic logic arb_lost_f(input logic [15:0] bus, input logic [3:0] id);
    logic [4:0] mine;
    logic res;
    mine = id[3] ? {2'b00, id[2:0]} : {2'b01, id[2:0]};
    res = 1'b0;
    for (int j = 0; j < 16; j++)
      if (bus[j] && (((j < 8) ? 5'(j + 8) : 5'(j - 8)) > mine))
        res = 1'b1;
    return res;
  endfunction

  // port pattern for each state that writes the differential port
  always_comb begin
    arb_wr = 1'b1;
    arb_adr = `SPD_DA_CTL;
    arb_dat = `SPD_DD_NONE;
    case (arb_reg)
      ARB_ASSERT: arb_dat = `SPD_DD_ARB;
      ARB_SELECT: arb_dat = `SPD_DD_SEL;
      ARB_BSY_OFF: arb_dat = `SPD_DD_SELONLY;
      ARB_DRV: begin
        arb_adr = `SPD_DA_ROLE;
        arb_dat = target_reg ? `SPD_DD_TARG : `SPD_DD_INIT;
      end
      ARB_RELEASE: arb_dat = `SPD_DD_NONE;
      ARB_LOST: arb_dat = `SPD_DD_NONE;
      default: arb_wr = 1'b0;
    endcase
  end

  // arbitration writes go first; an owed own-id write fills idle slots
  assign dw_req = !dw_busy && (arb_wr || id_pend_reg);
  assign arb_go = !dw_busy && arb_wr;
  assign dw_adr = arb_wr ? arb_adr : `SPD_DA_ID;
  assign dw_dat = arb_wr ? arb_dat : own_id_reg;

  spd_diff_wr u_diff (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .req_i(dw_req),
    .addr_i(dw_adr),
    .data_i(dw_dat),
    .busy_o(dw_busy),
    .adr_o(DIFF_PORT_ADDR_O),
    .dat_o(DIFF_PORT_DATA_O),
    .strb_o(DIFF_PORT_STROBE_O)
  );

  // a new id write while one is issued keeps the flag set
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I)
      id_pend_reg <= 1'b0;
    else if (id_wr)
      id_pend_reg <= 1'b1;
    else if (!dw_busy && !arb_wr)
      id_pend_reg <= 1'b0;
  end

  // arbitration and selection sequence
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      arb_reg <= ARB_IDLE;
      arb_cnt_reg <= 8'h00;
      won_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (chip_rst) begin
      // an abort still clears the control-address enables already sent out, not the role enables
      arb_reg <= (arb_reg == ARB_IDLE) ? ARB_IDLE : ARB_LOST;
    end else begin
      case (arb_reg)
        ARB_IDLE: if (arb_start) begin
          won_reg <= 1'b0;
          lost_reg <= 1'b0;
          arb_reg <= ARB_WAIT_FREE;
        end
        ARB_WAIT_FREE: if (bus_free_reg) arb_reg <= ARB_ASSERT;
        ARB_ASSERT: if (arb_go) begin
          arb_cnt_reg <= 8'h00;
          arb_reg <= ARB_DELAY;
        end
        ARB_DELAY: begin
          arb_cnt_reg <= arb_cnt_reg + 8'h01;
          if (arb_cnt_reg == 8'(`SPD_ARB_DELAY_CYC - 1)) begin
            if (arb_lost_f(bus_s, own_id_reg)) begin
              lost_reg <= 1'b1;
              arb_reg <= ARB_LOST;
            end else
              arb_reg <= ARB_SELECT;
          end
        end
        ARB_SELECT: if (arb_go) begin
          arb_cnt_reg <= 8'h00;
          arb_reg <= ARB_SEL_HOLD;
        end
        ARB_SEL_HOLD: begin
          arb_cnt_reg <= arb_cnt_reg + 8'h01;
          if (arb_cnt_reg == 8'(`SPD_SEL_HOLD_CYC - 1)) arb_reg <= ARB_BSY_OFF;
        end
        ARB_BSY_OFF: if (arb_go) arb_reg <= ARB_WAIT_BSY;
        ARB_WAIT_BSY: if (bsy_s) arb_reg <= ARB_DRV;
        ARB_DRV: if (arb_go) arb_reg <= ARB_RELEASE;
        ARB_RELEASE: if (arb_go) begin
          won_reg <= 1'b1;
          arb_reg <= ARB_IDLE;
        end
        ARB_LOST: if (arb_go) arb_reg <= ARB_IDLE;
        default: arb_reg <= ARB_IDLE;
      endcase
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    case (ADDR_I)
      `SPD_OFF_DEVCFG: rd_mux[`SPD_B_TPOL] = term_pol_reg;
      `SPD_OFF_XC0: rd_mux = {3'h0, target_reg, auto_reg, 3'h0};
      `SPD_OFF_XC1: rd_mux[`SPD_B_TEN] = term_en_reg;
      `SPD_OFF_HCTL: rd_mux[`SPD_B_PAUSE] = pause_reg;
      `SPD_OFF_OWNID: rd_mux = {4'h0, own_id_reg};
      `SPD_OFF_DLL: rd_mux = dll_reg;
      `SPD_OFF_DLH: rd_mux = dlh_reg;
      `SPD_OFF_SIGO: rd_mux = sigo_reg;
      `SPD_OFF_SIGI: rd_mux = ctl_s;
      `SPD_OFF_STAT0: rd_mux = {3'h0, (arb_reg != ARB_IDLE), lost_reg, won_reg,
                                ready_reg, bus_free_reg};
      `SPD_OFF_RATE: rd_mux = rate_reg;
      `SPD_OFF_BUSL: rd_mux = bus_s[7:0];
      `SPD_OFF_BUSH: rd_mux = bus_s[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I)
      RDATA_O <= 8'h00;
    else
      RDATA_O <= RD_I ? rd_mux : 8'h00;
  end

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  a_term_tristate: assert property (
    !rst_n_s |=> !TERM_POWER_OE_O && !term_en_reg && !term_pol_reg)
    else $error("termination not released during bus reset");
  a_term_stays: assert property (
    TERM_POWER_OE_O && rst_n_s |=> TERM_POWER_OE_O)
    else $error("termination drive dropped without bus reset");
  a_term_enable: assert property (
    rst_n_s && WR_I && ADDR_I == `SPD_OFF_XC1 && WDATA_I[0] && !term_pol_reg
    ##1 rst_n_s |-> ##1 TERM_POWER_OUT_O && TERM_POWER_OE_O)
    else $error("enable did not drive active high level");
  a_term_polarity: assert property (
    rst_n_s && $rose(term_pol_reg) && !term_en_reg |=> TERM_POWER_OUT_O)
    else $error("inactive level not high with low polarity");
  a_chip_reset: assert property (
    chip_rst && rst_n_s |=> !term_en_reg && term_pol_reg == $past(term_pol_reg))
    else $error("chip reset mishandled termination bits");
  a_init_ready: assert property (
    auto_reg && !target_reg && hs_reg == HS_IDLE && req_s && !chip_rst |=> ready_reg)
    else $error("ready not set on REQ as initiator");
  a_ack_release: assert property (
    auto_reg && !chip_rst && hs_reg == HS_STROBE && !target_reg && !req_s
    ##1 auto_reg |-> ##1 !SCSI_ACK_O)
    else $error("ACK kept after REQ dropped");
  a_cmd_async: assert property (
    cmd_phase |=> !SYNC_XFER_O && !WIDE_XFER_O)
    else $error("synchronous timing in command phase");
  a_id_port: assert property (
    id_wr |-> ##[1:40] (DIFF_PORT_STROBE_O && DIFF_PORT_ADDR_O == `SPD_DA_ID))
    else $error("own id not written to port address zero");
  a_strobe_pulse: assert property (
    DIFF_PORT_STROBE_O |=> !DIFF_PORT_STROBE_O && $stable(DIFF_PORT_ADDR_O)
    && $stable(DIFF_PORT_DATA_O))
    else $error("port strobe too long or fields moved");
  a_drv_order: assert property (
    arb_reg == ARB_WAIT_BSY && bsy_s && !chip_rst |=> arb_reg == ARB_DRV)
    else $error("driver enable not next after BSY answer");
endmodule

// file: design/spd_defines.svh
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH
// Summary of operation
// - polarity bit picks termination power active level
// - enable bit drives termination output active level
// - bus reset clears both bits, tri-states output
// - output stays tri-stated until enable written
// - soft chip reset clears enable, keeps polarity
// - power-on: paused, automatic functions off, bus-free flag
// - manual mode is a plain buffer via registers
// - auto mode handshakes while enable bit set
// - initiator out: ready on REQ, write sends ACK
// - initiator drops ACK after target drops REQ
// - initiator in: latch byte, read sends ACK
// - target out: read gives REQ, ACK captures
// - target in: write gives REQ, ACK ends it
// - rate register affects data phase, command async
// - differential port: four data, strobe, two address
// - own id write updates differential address zero
// - bus free, arbitrate, select, then drop busy
// - busy answer: drivers on, then select/busy off
// - after selection write address two role enables
`define SPD_CLK_MHZ 20
// register offsets
`define SPD_OFF_DEVCFG 4'h0
`define SPD_OFF_XC0 4'h1
`define SPD_OFF_XC1 4'h2
`define SPD_OFF_HCTL 4'h3
`define SPD_OFF_OWNID 4'h4
`define SPD_OFF_DLL 4'h5
`define SPD_OFF_DLH 4'h6
`define SPD_OFF_SIGO 4'h7
`define SPD_OFF_SIGI 4'h8
`define SPD_OFF_STAT0 4'h9
`define SPD_OFF_RATE 4'hA
`define SPD_OFF_ARB 4'hB
`define SPD_OFF_BUSL 4'hC
`define SPD_OFF_BUSH 4'hD
// field positions
`define SPD_B_TPOL 1
`define SPD_B_TEN 0
`define SPD_B_AUTO 3
`define SPD_B_TARGET 4
`define SPD_B_SOFT_CHIP_RESET 0
`define SPD_B_PAUSE 2
`define SPD_B_SIGO_ACK 0
`define SPD_B_SIGO_REQ 1
`define SPD_B_SIGO_DRV 7
`define SPD_B_READY 1
`define SPD_B_WIDE 7
`define SPD_B_START 0
// differential port addresses and patterns
`define SPD_DA_ID 2'h0
`define SPD_DA_CTL 2'h1
`define SPD_DA_ROLE 2'h2
`define SPD_DD_ARB 4'h5
`define SPD_DD_SEL 4'h3
`define SPD_DD_SELONLY 4'h2
`define SPD_DD_NONE 4'h0
`define SPD_DD_INIT 4'h5
`define SPD_DD_TARG 4'h6
// timing: figures in ns, cycle counts rounded up (least times)
`define SPD_BUS_FREE_NS 800
`define SPD_ARB_DELAY_NS 2400
`define SPD_SEL_HOLD_NS 1200
`define SPD_CYC(ns) (((ns) * `SPD_CLK_MHZ + 999) / 1000)
`define SPD_BUS_FREE_CYC `SPD_CYC(`SPD_BUS_FREE_NS)
`define SPD_ARB_DELAY_CYC `SPD_CYC(`SPD_ARB_DELAY_NS)
`define SPD_SEL_HOLD_CYC `SPD_CYC(`SPD_SEL_HOLD_NS)
`endif

// file: design/spd_pkg.sv
package spd_pkg;
  // pio handshake states
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_READY = 3'h1,
    HS_SETUP = 3'h2,
    HS_STROBE = 3'h3,
    HS_RELEASE = 3'h4
  } spd_hs_t;
  // arbitration and selection states
  typedef enum logic [3:0] {
    ARB_IDLE = 4'h0, ARB_WAIT_FREE = 4'h1, ARB_ASSERT = 4'h2, ARB_DELAY = 4'h3,
    ARB_SELECT = 4'h4, ARB_SEL_HOLD = 4'h5, ARB_BSY_OFF = 4'h6, ARB_WAIT_BSY = 4'h7,
    ARB_DRV = 4'h8, ARB_RELEASE = 4'h9, ARB_LOST = 4'hA
  } spd_arb_t;
endpackage

// file: design/spd_sync.sv
`timescale 1ns/1ns
module spd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic [W-1:0] d_i, // foreign level
  output logic [W-1:0] q_o // filtered level
);
  logic [W-1:0] s1_reg; // first stage, read only by s2
  logic [W-1:0] s2_reg; // second stage
  logic [W-1:0] s3_reg; // third stage
  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_o <= INIT;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o <= (s2_reg & s3_reg) | (q_o & (s2_reg ^ s3_reg));
    end
  end
endmodule

// file: design/spd_diff_wr.sv
`timescale 1ns/1ns
module spd_diff_wr (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic req_i, // write request, taken when not busy
  input wire logic [1:0] addr_i, // port address
  input wire logic [3:0] data_i, // port data
  output logic busy_o, // write in progress
  output logic [1:0] adr_o, // to external decode
  output logic [3:0] dat_o, // to external decode
  output logic strb_o // one-cycle strobe
);
  logic [1:0] phase_reg; // 0 idle, 1 setup, 2 strobe, 3 hold
  assign busy_o = (phase_reg != 2'h0);
  // fields settle a cycle before the strobe and hold a cycle after it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
      adr_o <= 2'h0;
      dat_o <= 4'h0;
      strb_o <= 1'b0;
    end else begin
      case (phase_reg)
        2'h0: if (req_i) begin
          adr_o <= addr_i;
          dat_o <= data_i;
          phase_reg <= 2'h1;
        end
        2'h1: begin
          strb_o <= 1'b1;
          phase_reg <= 2'h2;
        end
        2'h2: begin
          strb_o <= 1'b0;
          phase_reg <= 2'h3;
        end
        default: phase_reg <= 2'h0;
      endcase
    end
  end
endmodule

// file: verif/spd_peer.sv
`timescale 1ns/1ns
module spd_peer (
  input wire logic clk_i, // core clock
  input wire logic go_i, // request one byte
  input wire logic ack_i, // ACK from initiator
  output logic req_o, // REQ to initiator
  output logic io_o, // out direction
  output logic [15:0] data_o // data lines
);
  // idle lines toggle so a stale byte is never trusted
  initial begin
    req_o = 1'b0;
    data_o = 16'h5A5A;
  end
  assign io_o = 1'b0;
  // REQ up on request, down once ACK is seen
  always @(posedge clk_i) begin
    data_o <= ~data_o;
    if (go_i && !req_o && !ack_i) begin
      req_o <= 1'b1;
    end else if (ack_i) begin
      req_o <= 1'b0;
    end
  end
endmodule

// file: verif/spd_top_test.sv
`timescale 1ns/1ns
module spd_top_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rst_n = 1'b1, go = 1'b0;
  logic cd = 1'b0, bsy = 1'b0; // command phase and target BSY pins
  logic [3:0] addr = 4'h0; // register address
  logic [7:0] wdata = 8'h00, rdata, d; // register write data and read result
  logic req, io, req_o, ack_o, doe, tout, toe, sync, wide, pause, strb;
  logic [15:0] bus, dout;
  logic [3:0] ddat;
  logic [1:0] dadr;
  int failures = 0, cmp_count = 0, i;
  spd_top DUT (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SCSI_RST_N_I(rst_n), .SCSI_REQ_I(req), .SCSI_ACK_I(1'b0),
    .SCSI_IO_I(io), .SCSI_CD_I(cd), .SCSI_MSG_I(1'b0), .SCSI_BSY_I(bsy), .SCSI_SEL_I(1'b0),
    .SCSI_DATA_I(bus), .SCSI_REQ_O(req_o), .SCSI_ACK_O(ack_o), .SCSI_DATA_O(dout),
    .SCSI_DATA_OE_O(doe), .TERM_POWER_OUT_O(tout), .TERM_POWER_OE_O(toe), .SYNC_XFER_O(sync),
    .WIDE_XFER_O(wide), .SEQ_PAUSED_O(pause), .DIFF_PORT_DATA_O(ddat),
    .DIFF_PORT_STROBE_O(strb), .DIFF_PORT_ADDR_O(dadr));
  // target peer answering the initiator handshake
  spd_peer peer (.clk_i(clk), .go_i(go), .ack_i(ack_o), .req_o(req), .io_o(io), .data_o(bus));
  always #25 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a bound that runs out ends the run as a failure
  task automatic give_up(int n, int lim = 40);
    if (n >= lim) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] v);
    @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // wait for the next port strobe, decode it, then step past it
  task automatic wait_strb(logic [15:0] exp);
    for (i = 0; i < 60 && strb !== 1'b1; i++) @(posedge clk) #1;
    give_up(i, 60);
    check("diff port", {10'h0, dadr, ddat}, exp);
    @(posedge clk) #1;
  endtask
  // initiator out byte through auto mode
  task automatic t_pio;
    wr_reg(4'h1, 8'h08);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    for (i = 0; i < 40; i++) begin
      rd_reg(4'h9);
      if (d[1] === 1'b1) break;
    end
    give_up(i);
    wr_reg(4'h6, 8'hA5);
    wr_reg(4'h5, 8'h3C);
    for (i = 0; i < 40 && ack_o !== 1'b1; i++) @(posedge clk) #1;
    give_up(i);
    check("pio data", {7'h00, doe, dout[7:0]}, 16'h013C);
    check("pio word", dout, 16'hA53C);
    for (i = 0; i < 40 && ack_o !== 1'b0; i++) @(posedge clk) #1;
    give_up(i);
    rd_reg(4'h9);
    check("ready after ack", {15'h0, d[1]}, 16'h0000);
    $display("test pio done");
  endtask
  // own id write reaches differential address zero
  task automatic t_diff;
    wr_reg(4'h4, 8'h0B);
    for (i = 0; i < 40 && strb !== 1'b1; i++) @(posedge clk) #1;
    give_up(i);
    check("diff id", {10'h0, dadr, ddat}, 16'h000B);
    @(posedge clk) #1;
    check("strobe width", {15'h0, strb}, 16'h0000);
    $display("test diff done");
  endtask
  // termination power polarity, enable, chip reset, bus reset
  task automatic t_term;
    wr_reg(4'h0, 8'h02);
    repeat (2) @(posedge clk) #1;
    check("oe before enable", {15'h0, toe}, 16'h0000);
    wr_reg(4'h2, 8'h01);
    repeat (2) @(posedge clk) #1;
    check("low active on", {14'h0, toe, tout}, 16'h0002);
    wr_reg(4'h3, 8'h01);
    repeat (2) @(posedge clk) #1;
    check("chip reset off", {14'h0, toe, tout}, 16'h0003);
    @(posedge clk) rst_n <= 1'b0;
    repeat (8) @(posedge clk) #1;
    check("bus reset oe", {15'h0, toe}, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(4'h0);
    check("polarity cleared", {15'h0, d[1]}, 16'h0000);
    wr_reg(4'h2, 8'h01);
    repeat (2) @(posedge clk) #1;
    check("high active on", {14'h0, toe, tout}, 16'h0003);
    $display("test term done");
  endtask
  // manual drive, rate selects, and the command phase forcing async
  task automatic t_misc;
    wr_reg(4'h7, 8'h83);
    repeat (2) @(posedge clk) #1;
    check("manual drive", {13'h0, req_o, ack_o, doe}, 16'h0007);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'hA, 8'h81);
    repeat (2) @(posedge clk) #1;
    check("sync wide", {14'h0, sync, wide}, 16'h0003);
    @(posedge clk) cd <= 1'b1;
    repeat (6) @(posedge clk) #1;
    check("command async", {14'h0, sync, wide}, 16'h0000);
    @(posedge clk) cd <= 1'b0;
    $display("test misc done");
  endtask
  // the peer's data never settles, so the filtered bus is idle and we win
  task automatic t_arb;
    wr_reg(4'hB, 8'h01);
    wait_strb(16'h0015);
    wait_strb(16'h0013);
    wait_strb(16'h0012);
    @(posedge clk) bsy <= 1'b1;
    wait_strb(16'h0025);
    wait_strb(16'h0010);
    rd_reg(4'h9);
    check("arb won", {15'h0, d[2]}, 16'h0001);
    @(posedge clk) bsy <= 1'b0;
    $display("test arb done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    check("reset outputs", {14'h0, toe, pause}, 16'h0001);
    repeat (20) @(posedge clk);
    rd_reg(4'h9);
    check("bus free", {15'h0, d[0]}, 16'h0001);
    t_pio();
    t_diff();
    t_term();
    t_misc();
    t_arb();
    wrap_up();
  end
endmodule
